// ### hdl/dspd_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module dspd_cond_eval
    import dspd_pkg::*;
(
    input wire logic [15:0] word,
    input wire logic is_branch,
    input wire dspd_flags_t flags,
    output logic met
);

    logic [3:0] cur;
    logic [3:0] mask;
    logic [3:0] want;
    logic flag_ok;
    logic src_ok;

    always_comb
    begin
        cur = {flags.acc_zero, flags.acc_neg, flags.overflow, flags.carry};
        mask = word[3:0]; // [RL21]
        want = word[7:4];
        flag_ok = ((~(cur ^ want)) & mask) == mask;
        // Branch forms carry a fixed source of none; calls pick it from bits 9:8
        unique case (is_branch ? 2'h3 : word[9:8]) // [RL20]
            2'h0: src_ok = flags.io_status_low;
            2'h1: src_ok = flags.test_control_flag;
            2'h2: src_ok = !flags.test_control_flag;
            default: src_ok = 1'b1;
        endcase
        met = flag_ok && src_ok;
    end

endmodule
`default_nettype wire

// ### hdl/dspd_decoder.sv
// Contract
// (RL1) Branch if acc nonzero: two words, 4/2
// (RL2) Branch if acc zero, on overflow: same
// (RL3) Temp-selected and fixed-position bit tests decode
// (RL4) Block copy, immediate source: 2 words, 3
// (RL5) Block copy, immediate destination: 2 words, 3
// (RL6) Program-to-data copy: 2 words, 3 cycles
// (RL7) Call via acc 1/4; direct call 2/4
// (RL8) Conditional call: two words, 4/2 cycles
// (RL9) Configure block as data; enable interrupts
// (RL10) Low nibble selects which control bit clears
// (RL11) Invert accumulator: one word, one cycle
// (RL12) Compare aux to first aux, set flag
// (RL13) Move data word to next address
// (RL14) Idle until interrupt, one cycle issue
// (RL15) Port input: two words, two cycles
// (RL16) Accumulator load with left shift count
// (RL17) Long immediate accumulator load: 2/2
// (RL18) Clear low half, load high half
// (RL19) Block copy unsafe with interrupt/alloc registers
// (RL20) Condition source bits select extra condition
// (RL21) Mask nibble selects tested flags, state
// (RL22) Second word fetched as operand only
// (RL23) Unknown opcodes passed to neighbour decoders
`timescale 1ns/1ps
`default_nettype none
module dspd_decoder
    import dspd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire dspd_flags_t flags,
    output logic fetch_operand,
    output dspd_dec_t dec
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef enum logic [1:0] {
        DSPD_ST_OPCODE = 2'b00,
        DSPD_ST_OPERAND = 2'b01
    } dspd_st_t;

    typedef struct packed {
        dspd_st_t st;
        logic fetch;
        dspd_dec_t pend;
        dspd_dec_t out;
    } dspd_state_t;

    dspd_state_t s_q;
    dspd_state_t s_d;
    dspd_cls_t cls;
    logic met;

    ////////////////////////////////////////////////////////////////////////////////
    // Classification

    dspd_opcode_match u_match (
        .word(instr_word),
        .cls(cls)
    );

    dspd_cond_eval u_cond (
        .word(instr_word),
        .is_branch(cls.op == DSPD_OP_COND_BRANCH),
        .flags(flags),
        .met(met)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_d = s_q;
        s_d.out.valid = 1'b0;
        s_d.out.pass_on = 1'b0;
        s_d.fetch = 1'b0;
        if (instr_valid)
        begin
            unique case (s_q.st)
                DSPD_ST_OPCODE:
                begin
                    s_d.pend = '0;
                    s_d.pend.valid = 1'b1;
                    s_d.pend.op = cls.op;
                    s_d.pend.two_words = cls.two_words;
                    s_d.pend.cond_met = cls.conditional ? met : 1'b1; // [RL21]
                    // Not-taken costs two cycles; taken costs four
                    s_d.pend.cycles = (cls.conditional && !met) ? cls.cyc_not
                                                                : cls.cyc_taken; // [RL1] [RL8]
                    s_d.pend.clr_sel = cls.clr_sel; // [RL10]
                    s_d.pend.field_hi = instr_word[11:8]; // [RL3] [RL16]
                    s_d.pend.low_byte = instr_word[7:0];
                    // Flags copies that may hit memory-mapped irq/alloc registers
                    s_d.pend.no_mmr_copy = (cls.op == DSPD_OP_BLK_SRC_IMM)
                        || (cls.op == DSPD_OP_BLK_DST_IMM); // [RL19]
                    s_d.pend.pass_on = (cls.op == DSPD_OP_NONE); // [RL23]
                    if (cls.two_words)
                    begin
                        s_d.st = DSPD_ST_OPERAND; // [RL22]
                        s_d.fetch = 1'b1;
                    end
                    else
                    begin
                        s_d.out = s_d.pend;
                    end
                end
                default:
                begin
                    // Second word never reaches opcode matching
                    s_d.pend.operand = instr_word; // [RL22]
                    s_d.out = s_d.pend;
                    s_d.out.operand = instr_word;
                    s_d.st = DSPD_ST_OPCODE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fetch_operand = s_q.fetch;
    assign dec = s_q.out;

endmodule
`default_nettype wire

// ### hdl/dspd_opcode_match.sv
`timescale 1ns/1ps
`default_nettype none
module dspd_opcode_match
    import dspd_pkg::*;
(
    input wire logic [15:0] word,
    output dspd_cls_t cls
);

    always_comb
    begin
        cls = '0;
        cls.op = DSPD_OP_NONE;
        cls.clr_sel = DSPD_CLR_NONE;
        if (word == DSPD_BR_NZ_OP || word == DSPD_BR_Z_OP || word == DSPD_BR_OV_OP)
        begin
            cls.op = DSPD_OP_COND_BRANCH; // [RL1] [RL2]
            cls.two_words = 1'b1;
            cls.conditional = 1'b1;
            cls.cyc_taken = DSPD_CYC_4;
            cls.cyc_not = DSPD_CYC_2;
        end
        else if (word[15:10] == DSPD_CCALL_HI6)
        begin
            cls.op = DSPD_OP_COND_JUMP; // [RL8]
            cls.two_words = 1'b1;
            cls.conditional = 1'b1;
            cls.cyc_taken = DSPD_CYC_4;
            cls.cyc_not = DSPD_CYC_2;
        end
        else if (word[15:8] == DSPD_BIT_TEMP_HI)
        begin
            cls.op = DSPD_OP_POS_TEST_TEMP; // [RL3]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:12] == DSPD_BIT_FIX_NIB)
        begin
            cls.op = DSPD_OP_BIT_FIXED; // [RL3]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:8] == DSPD_BLK_SRC_HI || word[15:8] == DSPD_BLK_DST_HI
            || word[15:8] == DSPD_BLK_PRG_HI)
        begin
            cls.op = (word[15:8] == DSPD_BLK_SRC_HI) ? DSPD_OP_BLK_SRC_IMM : // [RL4]
                     (word[15:8] == DSPD_BLK_DST_HI) ? DSPD_OP_BLK_DST_IMM : // [RL5]
                     DSPD_OP_PRG_TO_DATA; // [RL6]
            cls.two_words = 1'b1;
            cls.cyc_taken = DSPD_CYC_3;
        end
        else if (word == DSPD_CALL_ACC_OP)
        begin
            cls.op = DSPD_OP_JUMP_VIA_ACC; // [RL7]
            cls.cyc_taken = DSPD_CYC_4;
        end
        else if (word[15:8] == DSPD_CALL_DIR_HI)
        begin
            cls.op = DSPD_OP_JUMP_DIRECT; // [RL7]
            cls.two_words = 1'b1;
            cls.cyc_taken = DSPD_CYC_4;
        end
        else if (word == DSPD_CFG_DATA_OP)
        begin
            cls.op = DSPD_OP_CFG_DATA; // [RL9]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word == DSPD_INT_EN_OP)
        begin
            cls.op = DSPD_OP_INT_ENABLE; // [RL9]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:4] == DSPD_CLR_PFX && (word[3:0] == DSPD_CLR_CARRY
            || word[3:0] == DSPD_CLR_OVM || word[3:0] == DSPD_CLR_SXM
            || word[3:0] == DSPD_CLR_TC || word[3:0] == DSPD_CLR_XF))
        begin
            cls.op = DSPD_OP_CTRL_CLEAR; // [RL10]
            cls.cyc_taken = DSPD_CYC_1;
            unique case (word[3:0])
                DSPD_CLR_CARRY: cls.clr_sel = DSPD_CLR_CARRY_BIT;
                DSPD_CLR_OVM: cls.clr_sel = DSPD_CLR_OVM_BIT;
                DSPD_CLR_SXM: cls.clr_sel = DSPD_CLR_SXM_BIT;
                DSPD_CLR_TC: cls.clr_sel = DSPD_CLR_TC_BIT;
                default: cls.clr_sel = DSPD_CLR_XF_BIT;
            endcase
        end
        else if (word == DSPD_INV_OP)
        begin
            cls.op = DSPD_OP_ACC_INVERT; // [RL11]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:2] == DSPD_CMP_HI14)
        begin
            cls.op = DSPD_OP_AUX_COMPARE; // [RL12]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:8] == DSPD_DATA_WORD_SHIFT_MOVE_HI)
        begin
            cls.op = DSPD_OP_DATA_MOVE; // [RL13]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word == DSPD_IDLE_OP)
        begin
            cls.op = DSPD_OP_IDLE; // [RL14]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:8] == DSPD_IN_HI)
        begin
            cls.op = DSPD_OP_PORT_IN; // [RL15]
            cls.two_words = 1'b1;
            cls.cyc_taken = DSPD_CYC_2;
        end
        else if (word[15:5] == DSPD_TRAP_HI11)
        begin
            cls.op = DSPD_OP_TRAP;
            cls.cyc_taken = DSPD_CYC_4;
        end
        else if (word[15:12] == DSPD_LDSH_NIB)
        begin
            cls.op = DSPD_OP_ACC_LOAD_SHIFT; // [RL16]
            cls.cyc_taken = DSPD_CYC_1;
        end
        else if (word[15:4] == DSPD_LDLI_PFX)
        begin
            cls.op = DSPD_OP_ACC_LOAD_LONG; // [RL17]
            cls.two_words = 1'b1;
            cls.cyc_taken = DSPD_CYC_2;
        end
        else if (word[15:8] == DSPD_LDHI_HI)
        begin
            cls.op = DSPD_OP_ACC_LOAD_HIGH; // [RL18]
            cls.cyc_taken = DSPD_CYC_1;
        end
        if (!cls.conditional)
        begin
            cls.cyc_not = cls.cyc_taken;
        end
    end

endmodule
`default_nettype wire

// ### hdl/dspd_pkg.sv
package dspd_pkg;

    // Opcode patterns and masks
    localparam logic [15:0] DSPD_BR_NZ_OP = 16'hE308;
    localparam logic [15:0] DSPD_BR_Z_OP = 16'hE388;
    localparam logic [15:0] DSPD_BR_OV_OP = 16'hE322;
    localparam logic [7:0] DSPD_BIT_TEMP_HI = 8'h6F;
    localparam logic [3:0] DSPD_BIT_FIX_NIB = 4'h4;
    localparam logic [7:0] DSPD_BLK_SRC_HI = 8'hA8;
    localparam logic [7:0] DSPD_BLK_DST_HI = 8'hA9;
    localparam logic [7:0] DSPD_BLK_PRG_HI = 8'hA5;
    localparam logic [15:0] DSPD_CALL_ACC_OP = 16'hBE30;
    localparam logic [7:0] DSPD_CALL_DIR_HI = 8'h7A;
    localparam logic [5:0] DSPD_CCALL_HI6 = 6'h3A;
    localparam logic [15:0] DSPD_CFG_DATA_OP = 16'hBE44;
    localparam logic [15:0] DSPD_INT_EN_OP = 16'hBE40;
    localparam logic [11:0] DSPD_CLR_PFX = 12'hBE4;
    localparam logic [3:0] DSPD_CLR_CARRY = 4'hE;
    localparam logic [3:0] DSPD_CLR_OVM = 4'h2;
    localparam logic [3:0] DSPD_CLR_SXM = 4'h6;
    localparam logic [3:0] DSPD_CLR_TC = 4'hA;
    localparam logic [3:0] DSPD_CLR_XF = 4'hC;
    localparam logic [15:0] DSPD_INV_OP = 16'hBE01;
    localparam logic [13:0] DSPD_CMP_HI14 = 14'h2FD1;
    localparam logic [7:0] DSPD_DATA_WORD_SHIFT_MOVE_HI = 8'h77;
    localparam logic [15:0] DSPD_IDLE_OP = 16'hBE22;
    localparam logic [7:0] DSPD_IN_HI = 8'hAF;
    localparam logic [10:0] DSPD_TRAP_HI11 = 11'h5F3;
    localparam logic [3:0] DSPD_LDSH_NIB = 4'h1;
    localparam logic [11:0] DSPD_LDLI_PFX = 12'hBF8;
    localparam logic [7:0] DSPD_LDHI_HI = 8'h6A;

    // Cycle costs
    localparam logic [2:0] DSPD_CYC_1 = 3'h1;
    localparam logic [2:0] DSPD_CYC_2 = 3'h2;
    localparam logic [2:0] DSPD_CYC_3 = 3'h3;
    localparam logic [2:0] DSPD_CYC_4 = 3'h4;

    typedef enum logic [4:0] {
        DSPD_OP_NONE = 5'h00,
        DSPD_OP_COND_BRANCH = 5'h01,
        DSPD_OP_BIT_FIXED = 5'h02,
        DSPD_OP_POS_TEST_TEMP = 5'h03,
        DSPD_OP_BLK_SRC_IMM = 5'h04,
        DSPD_OP_BLK_DST_IMM = 5'h05,
        DSPD_OP_PRG_TO_DATA = 5'h06,
        DSPD_OP_JUMP_VIA_ACC = 5'h07,
        DSPD_OP_JUMP_DIRECT = 5'h08,
        DSPD_OP_COND_JUMP = 5'h09,
        DSPD_OP_CFG_DATA = 5'h0A,
        DSPD_OP_INT_ENABLE = 5'h0B,
        DSPD_OP_CTRL_CLEAR = 5'h0C,
        DSPD_OP_ACC_INVERT = 5'h0D,
        DSPD_OP_AUX_COMPARE = 5'h0E,
        DSPD_OP_DATA_MOVE = 5'h0F,
        DSPD_OP_IDLE = 5'h10,
        DSPD_OP_PORT_IN = 5'h11,
        DSPD_OP_TRAP = 5'h12,
        DSPD_OP_ACC_LOAD_SHIFT = 5'h13,
        DSPD_OP_ACC_LOAD_LONG = 5'h14,
        DSPD_OP_ACC_LOAD_HIGH = 5'h15
    } dspd_op_t;

    typedef enum logic [2:0] {
        DSPD_CLR_NONE = 3'h0,
        DSPD_CLR_CARRY_BIT = 3'h1,
        DSPD_CLR_OVM_BIT = 3'h2,
        DSPD_CLR_SXM_BIT = 3'h3,
        DSPD_CLR_TC_BIT = 3'h4,
        DSPD_CLR_XF_BIT = 3'h5
    } dspd_clr_t;

    // Core condition flags fed to the decoder
    typedef struct packed {
        logic acc_zero;
        logic acc_neg;
        logic overflow;
        logic carry;
        logic test_control_flag;
        logic io_status_low;
    } dspd_flags_t;

    // One decoded instruction
    typedef struct packed {
        logic valid;
        dspd_op_t op;
        logic two_words;
        logic [2:0] cycles;
        logic cond_met;
        dspd_clr_t clr_sel;
        logic [3:0] field_hi;
        logic [7:0] low_byte;
        logic no_mmr_copy;
        logic pass_on;
        logic [15:0] operand;
    } dspd_dec_t;

    // Per-opcode classification from the combinational decoder
    typedef struct packed {
        dspd_op_t op;
        logic two_words;
        logic conditional;
        logic [2:0] cyc_taken;
        logic [2:0] cyc_not;
        dspd_clr_t clr_sel;
    } dspd_cls_t;

endpackage

// ### verif/dspd_decoder_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dspd_decoder_assertions
    import dspd_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire dspd_flags_t flags,
    input wire logic fetch_operand,
    input wire dspd_dec_t dec
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    sequence s_cond_done;
        dec.valid && dec.op inside {DSPD_OP_COND_BRANCH, DSPD_OP_COND_JUMP};
    endsequence

    sequence s_copy_done;
        dec.valid && dec.op inside {DSPD_OP_BLK_SRC_IMM, DSPD_OP_BLK_DST_IMM};
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Every taken word yields exactly one answer: a fetch request or a result
    chk_one_answer: assert property (instr_valid |=> fetch_operand ^ dec.valid)
        else $error("taken word did not give exactly one answer");
    chk_no_answer: assert property (!instr_valid |=> !fetch_operand && !dec.valid)
        else $error("answer without a taken word");
    chk_operand_word: assert property (fetch_operand && instr_valid |=>
        dec.valid && dec.two_words && dec.operand == $past(instr_word))
        else $error("second word not returned as operand");
    chk_fetch_pulse: assert property (fetch_operand |=> !fetch_operand)
        else $error("fetch request longer than one cycle");
    chk_cond_cost: assert property (s_cond_done |-> dec.two_words &&
        dec.cycles == (dec.cond_met ? DSPD_CYC_4 : DSPD_CYC_2))
        else $error("conditional cost wrong");
    chk_copy_guard: assert property (s_copy_done |-> dec.no_mmr_copy &&
        dec.two_words && dec.cycles == DSPD_CYC_3)
        else $error("data block copy decode wrong");
    chk_pass_none: assert property (dec.valid && dec.pass_on |-> dec.op == DSPD_OP_NONE)
        else $error("passed-on word has an operation");
    chk_short_fields: assert property (dec.valid && !dec.two_words |->
        {dec.field_hi, dec.low_byte} == $past(instr_word[11:0]))
        else $error("opcode fields not copied");
    // Past reset is excluded because reset legally clears the held fields
    chk_fields_hold: assert property (!dec.valid && !$past(rst) |->
        $stable(dec.op) && $stable(dec.operand))
        else $error("result fields changed without a result");
endmodule
`default_nettype wire

// ### verif/dspd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module dspd_decoder_test
    import dspd_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    dspd_flags_t flags = '0;
    logic fetch_operand;
    dspd_dec_t dec;
    dspd_dec_t me;
    int n_errors = 0;
    int check_count = 0;
    int seed = 32'h2ab0fc96;
    int cyc = 0;
    int exp_fetch = 0;
    int got_fetch = 0;
    dspd_dec_t expq[$];
    logic [15:0] ops[36] = '{16'hE308, 16'hE388, 16'hE322, 16'hE8F1, 16'hE980, 16'hEA0C,
        16'hEB22, 16'h4A55, 16'h6F12, 16'hA834, 16'hA9FF, 16'hA501, 16'hBE30, 16'h7A40,
        16'hBE44, 16'hBE40, 16'hBE4E, 16'hBE42, 16'hBE46, 16'hBE4A, 16'hBE4C, 16'hBE01,
        16'hBF44, 16'hBF47, 16'h7703, 16'hBE22, 16'hAF10, 16'hBE60, 16'hBE7F, 16'h1F80,
        16'hBF83, 16'h6A05, 16'hBE48, 16'hE300, 16'h0000, 16'hFFFF};

    initial forever #2.5 clk_sys = ~clk_sys;

    dspd_decoder dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .flags(flags),
        .fetch_operand(fetch_operand),
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    function automatic dspd_dec_t model(input logic [15:0] w, input dspd_flags_t f);
        dspd_dec_t e;
        logic [4:0] k;
        logic t;
        logic [2:0] c;
        logic [2:0] r;
        logic [3:0] z;
        logic s;
        e = '0;
        {k, t, c, r} = {5'h00, 1'b0, 3'h1, 3'h0};
        z = {f.acc_zero, f.acc_neg, f.overflow, f.carry};
        s = w[9] ? (w[8] | ~f.test_control_flag) : (w[8] ? f.test_control_flag : f.io_status_low);
        e.cond_met = (((z ^ w[7:4]) & w[3:0]) == 4'h0);
        if (w == 16'hE308 || w == 16'hE388 || w == 16'hE322)
            k = DSPD_OP_COND_BRANCH;
        else if (w[15:10] == 6'h3A)
        begin
            k = DSPD_OP_COND_JUMP;
            e.cond_met = e.cond_met && s;
        end
        else if (w[15:12] == 4'h4)
            k = DSPD_OP_BIT_FIXED;
        else if (w[15:12] == 4'h1)
            k = DSPD_OP_ACC_LOAD_SHIFT;
        else if (w[15:2] == 14'h2FD1)
            k = DSPD_OP_AUX_COMPARE;
        else if (w[15:4] == 12'hBF8)
            {k, t, c} = {DSPD_OP_ACC_LOAD_LONG, 1'b1, 3'h2};
        else if (w[15:5] == 11'h5F3)
            {k, c} = {DSPD_OP_TRAP, 3'h4};
        else
            case (w[15:8])
                8'h6F: k = DSPD_OP_POS_TEST_TEMP;
                8'hA8: {k, t, c} = {DSPD_OP_BLK_SRC_IMM, 1'b1, 3'h3};
                8'hA9: {k, t, c} = {DSPD_OP_BLK_DST_IMM, 1'b1, 3'h3};
                8'hA5: {k, t, c} = {DSPD_OP_PRG_TO_DATA, 1'b1, 3'h3};
                8'h7A: {k, t, c} = {DSPD_OP_JUMP_DIRECT, 1'b1, 3'h4};
                8'h77: k = DSPD_OP_DATA_MOVE;
                8'hAF: {k, t, c} = {DSPD_OP_PORT_IN, 1'b1, 3'h2};
                8'h6A: k = DSPD_OP_ACC_LOAD_HIGH;
                8'hBE:
                    case (w[7:0])
                        8'h30: {k, c} = {DSPD_OP_JUMP_VIA_ACC, 3'h4};
                        8'h44: k = DSPD_OP_CFG_DATA;
                        8'h40: k = DSPD_OP_INT_ENABLE;
                        8'h01: k = DSPD_OP_ACC_INVERT;
                        8'h22: k = DSPD_OP_IDLE;
                        8'h4E: {k, r} = {DSPD_OP_CTRL_CLEAR, 3'h1};
                        8'h42: {k, r} = {DSPD_OP_CTRL_CLEAR, 3'h2};
                        8'h46: {k, r} = {DSPD_OP_CTRL_CLEAR, 3'h3};
                        8'h4A: {k, r} = {DSPD_OP_CTRL_CLEAR, 3'h4};
                        8'h4C: {k, r} = {DSPD_OP_CTRL_CLEAR, 3'h5};
                        default: k = 5'h00;
                    endcase
                default: k = 5'h00;
            endcase
        if (k == DSPD_OP_COND_BRANCH || k == DSPD_OP_COND_JUMP)
            {t, c} = {1'b1, e.cond_met ? 3'h4 : 3'h2};
        e.valid = 1'b1;
        e.op = dspd_op_t'(k);
        e.two_words = t;
        e.cycles = c;
        e.clr_sel = dspd_clr_t'(r);
        e.field_hi = w[11:8];
        e.low_byte = w[7:0];
        e.pass_on = (k == 5'h00);
        e.no_mmr_copy = (w[15:9] == 7'h54);
        return e;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic put(input logic v, input logic [15:0] w, input dspd_flags_t f);
        @(posedge clk_sys);
        instr_valid <= v;
        instr_word <= w;
        flags <= f;
    endtask

    task automatic instr(input logic [15:0] w, input logic [15:0] opnd);
        dspd_dec_t e;
        dspd_flags_t f;
        f = 6'($random(seed));
        e = model(w, f);
        e.operand = opnd;
        expq.push_back(e);
        put(1'b1, w, f);
        if (e.two_words)
        begin
            exp_fetch++;
            // Flags beside the operand differ so a late sample shows up
            put(1'b1, opnd, ~f);
        end
    endtask

    task automatic gap(input int n);
        repeat (n) put(1'b0, 16'($random(seed)), 6'($random(seed)));
    endtask

    always @(negedge clk_sys)
    begin
        if (fetch_operand === 1'b1)
            got_fetch++;
        if (dec.valid === 1'b1 && expq.size() == 0)
            chk(32'h1, 32'h0);
        else if (dec.valid === 1'b1)
        begin
            me = expq.pop_front();
            chk(dec.op, me.op);
            chk(dec.pass_on, me.pass_on);
            chk({dec.field_hi, dec.low_byte}, {me.field_hi, me.low_byte});
            if (!me.pass_on)
                chk({dec.two_words, dec.cycles}, {me.two_words, me.cycles});
            if (me.two_words)
                chk(dec.operand, me.operand);
            if (me.op == DSPD_OP_COND_BRANCH || me.op == DSPD_OP_COND_JUMP)
                chk(dec.cond_met, me.cond_met);
            // Compared for every result so a stray clear or guard also shows up
            chk(dec.clr_sel, me.clr_sel);
            chk(dec.no_mmr_copy, me.no_mmr_copy);
        end
    end

    // Ceiling well above the roughly 1350 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // Operands shaped like opcodes must never be decoded as such
        foreach (ops[i])
            instr(ops[i], ops[(i + 1) % 36]);
        repeat (20)
            for (int i = 0; i < 7; i++)
                instr(ops[i], 16'($random(seed)));
        gap(3);
        rst <= 1'b1;
        repeat (2) @(negedge clk_sys);
        chk({fetch_operand, dec.valid, dec.op, dec.operand}, 23'h0);
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (300)
        begin
            instr({6'h3A, 10'($random(seed))}, 16'($random(seed)));
            instr(16'($random(seed)), 16'($random(seed)));
            if ($random(seed) % 4 == 0)
                gap(1);
        end
        gap(4);
        chk(got_fetch, exp_fetch);
        chk(expq.size(), 0);
        test_done();
    end
endmodule

bind dspd_decoder dspd_decoder_assertions u_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .flags(flags),
    .fetch_operand(fetch_operand),
    .dec(dec)
);
`default_nettype wire
